// >>> hw/sac_ctrl.sv
`timescale 1ns/100ps
// Function
// R1: chip select high releases data output
// R2: debounced high select freezes internal state
// R3: debounced low select resets the device
// R4: host keeps clock low after select
// R5: abort keeps old result for next cycle
// R6: host normally keeps chip select low
// R7: command 1110 powers down at fourth fall
// R8: power down: no conversion, result kept
// R9: serial logic runs through power down cycle
// R10: power-on state is power down
// R11: other command wakes and converts after cycle
// R12: codes 0 to 10 pick external channels
// R13: codes 11 to 13 pick test voltages
// R14: selector breaks before it makes
// R15: sample from fourth fall to last fall
// R16: twelve bits decided msb to lsb
// R17: above trip gives 0, weight dropped
// R18: result saturates at both references
// R19: length 01 is 8, 11 is 16
// R20: end flag high in reset, low converting
// R21: steps paced by internal conversion clock
module sac_ctrl #(
  parameter int DEB_CYCLES = sac_pkg::DEB_CYC,
  parameter int STEP_CYCLES = sac_pkg::CONV_STEP_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host serial pins
  input wire logic cs_n,
  input wire logic io_clk,
  input wire logic data_in,
  output logic data_out,
  output logic data_out_oe,
  output logic eoc,
  // analog front end
  input wire logic cmp_above,
  output logic [3:0] mux_sel,
  output logic mux_connect,
  output logic sample_close,
  output logic [sac_pkg::RES_W-1:0] trial_weights,
  output logic power_down
);
  import sac_pkg::*;

  logic [3:0] sy1_r;
  logic [3:0] sy2_r;
  logic clk_d_r;
  logic cs_low_r;
  logic [$clog2(DEB_CYCLES+1)-1:0] deb_r;
  logic dev_rst;
  logic rise;
  logic fall;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] last_cnt;
  logic [7:0] cmd_r;
  logic [1:0] len_r;
  logic lsb_r;
  logic bip_r;
  logic pd_r;
  logic sel_pend_r;
  logic [3:0] mux_sel_r;
  logic mux_con_r;
  logic samp_r;
  logic eoc_r;
  logic conv_start;
  logic sar_busy;
  logic sar_done;
  logic [RES_W-1:0] sar_res;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] sh_r;

  // =====================================================
  // pin synchronisers: first stage read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sy1_r <= SY_RST;
      sy2_r <= SY_RST;
      clk_d_r <= 1'b0;
    end else begin
      sy1_r <= {cmp_above, data_in, io_clk, cs_n};
      sy2_r <= sy1_r;
      clk_d_r <= sy2_r[SY_CLK];
    end
  end

  // release the shared line as soon as select is seen high
  assign data_out_oe = ~sy2_r[SY_CS]; // R1

  // =====================================================
  // select debounce: level must hold for the full interval
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      deb_r <= '0;
      cs_low_r <= 1'b0;
    end else if (sy2_r[SY_CS] == cs_low_r) begin
      if (deb_r == DEB_CYCLES[$bits(deb_r)-1:0] - 1'b1) begin
        deb_r <= '0;
        cs_low_r <= ~sy2_r[SY_CS]; // R3
      end else begin
        deb_r <= deb_r + 1'b1;
      end
    end else begin
      deb_r <= '0;
    end
  end

  // device reset on the debounced falling select
  assign dev_rst = ~cs_low_r & ~sy2_r[SY_CS] & (deb_r == DEB_CYCLES[$bits(deb_r)-1:0] - 1'b1); // R3
  // host clock ignored while debounced high or while converting
  assign rise = sy2_r[SY_CLK] & ~clk_d_r & cs_low_r & ~sar_busy; // R2
  assign fall = ~sy2_r[SY_CLK] & clk_d_r & cs_low_r & ~sar_busy; // R2
  assign cnt_nxt = cnt_r + 1'b1;

  // cycle length from the field seen so far
  always_comb begin
    case (len_r)
      LEN_8: last_cnt = BITS_8; // R19
      LEN_16: last_cnt = BITS_16; // R19
      default: last_cnt = BITS_12;
    endcase
  end

  assign conv_start = fall & (cnt_nxt == last_cnt) & ~pd_r; // R19

  // =====================================================
  // command shift and edge count
  always_ff @(posedge sys_clk) begin
    if (!rstn || dev_rst) begin
      cnt_r <= '0;
      cmd_r <= '0;
    end else begin
      if (rise && cnt_r < CMD_EDGE) begin
        cmd_r <= {cmd_r[6:0], sy2_r[SY_DIN]};
      end
      if (fall) begin
        // full-length cycle runs even when it selected power down
        cnt_r <= (cnt_nxt == last_cnt) ? '0 : cnt_nxt; // R9
      end
    end
  end

  // length and output options latched at their edges
  always_ff @(posedge sys_clk) begin
    if (!rstn || dev_rst) begin
      len_r <= LEN_RST;
    end else if (fall && cnt_nxt == LEN_EDGE) begin
      len_r <= cmd_r[1:0];
    end else if (conv_start || (fall && cnt_nxt == last_cnt)) begin
      len_r <= len_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lsb_r <= 1'b0;
      bip_r <= 1'b0;
    end else if (fall && cnt_nxt == CMD_EDGE) begin
      lsb_r <= cmd_r[1];
      bip_r <= cmd_r[0];
    end
  end

  // =====================================================
  // power down: entered on fourth fall, left by any other address
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pd_r <= 1'b1; // R10
    end else if (fall && cnt_nxt == ADDR_EDGE) begin
      pd_r <= (cmd_r[3:0] == CMD_PDOWN); // R7 R11
    end
  end

  // =====================================================
  // input selector: open switch, change address, then close
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sel_pend_r <= 1'b0;
      mux_sel_r <= '0;
      mux_con_r <= 1'b0;
      samp_r <= 1'b0;
    end else if (dev_rst || conv_start) begin
      sel_pend_r <= 1'b0;
      mux_con_r <= 1'b0;
      samp_r <= 1'b0; // R15
    end else if (fall && cnt_nxt == ADDR_EDGE && cmd_r[3:0] != CMD_PDOWN) begin
      sel_pend_r <= 1'b1;
      mux_con_r <= 1'b0; // R14
    end else if (sel_pend_r && !mux_con_r && mux_sel_r != cmd_r[3:0]) begin
      mux_sel_r <= cmd_r[3:0]; // R12 R13
    end else if (sel_pend_r) begin
      sel_pend_r <= 1'b0;
      mux_con_r <= 1'b1; // R14
      samp_r <= 1'b1; // R15
    end
  end

  // =====================================================
  // end flag: low from sample hold until result latched
  always_ff @(posedge sys_clk) begin
    if (!rstn || dev_rst || sar_done) begin
      eoc_r <= 1'b1; // R20
    end else if (conv_start) begin
      eoc_r <= 1'b0; // R20
    end
  end

  // formatted output word: sign flip, truncation, bit order
  function automatic logic [WORD_W-1:0] fmt(input logic [RES_W-1:0] res, input logic [1:0] len,
                                            input logic lsb, input logic bip);
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] rev;
    logic [CNT_W-1:0] n;
    w = {res[RES_W-1] ^ bip, res[RES_W-2:0], 4'h0};
    n = (len == LEN_8) ? BITS_8 : (len == LEN_16) ? BITS_16 : BITS_12;
    for (int i = 0; i < WORD_W; i++) begin
      rev[i] = w[WORD_W-1-i];
    end
    if (lsb) begin
      w = rev << (BITS_16 - n);
    end
    return w;
  endfunction

  // =====================================================
  // result buffer and output shifter
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      word_r <= WORD_RST;
    end else if (sar_done) begin
      word_r <= fmt(sar_res, len_r, lsb_r, bip_r);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sh_r <= WORD_RST;
    end else if (sar_done) begin
      sh_r <= fmt(sar_res, len_r, lsb_r, bip_r);
    end else if (dev_rst) begin
      // aborted conversion leaves the older word to shift out
      sh_r <= word_r; // R5
    end else if (conv_start) begin
      sh_r <= WORD_RST; // output forced low while converting
    end else if (fall && cnt_nxt == last_cnt && pd_r) begin
      sh_r <= word_r; // R8 a power down cycle leaves the buffered word to shift out again
    end else if (fall) begin
      sh_r <= {sh_r[WORD_W-2:0], 1'b0};
    end
  end

  // =====================================================
  // approximation engine
  sac_sar #(
    .WIDTH(RES_W),
    .STEP_CYC(STEP_CYCLES)
  ) u_sar (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(conv_start), // R8
    .abort(dev_rst), // R5
    .cmp_above(sy2_r[SY_CMP]),
    .busy(sar_busy),
    .done(sar_done),
    .trial_r(trial_weights),
    .result_r(sar_res)
  );

  assign data_out = sh_r[WORD_W-1];
  assign eoc = eoc_r;
  assign mux_sel = mux_sel_r;
  assign mux_connect = mux_con_r;
  assign sample_close = samp_r;
  assign power_down = pd_r;

  // =====================================================
  // checks
  property p_release;
    @(posedge sys_clk) disable iff (!rstn) sy2_r[SY_CS] |-> !data_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected"); // R1

  property p_frozen;
    @(posedge sys_clk) disable iff (!rstn)
      (!cs_low_r && $past(!cs_low_r)) |-> ($stable(cnt_r) && $stable(cmd_r));
  endproperty
  a_frozen: assert property (p_frozen) else $error("state changed while deselected"); // R2

  property p_cs_reset;
    @(posedge sys_clk) disable iff (!rstn) $rose(cs_low_r) |-> (cnt_r == '0 && eoc_r);
  endproperty
  a_cs_reset: assert property (p_cs_reset) else $error("select did not reset the device"); // R3

  property p_abort_keep;
    @(posedge sys_clk) disable iff (!rstn) (dev_rst && sar_busy) |=> (sh_r == word_r && !sar_busy);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort lost the buffered result"); // R5

  property p_pd_enter;
    @(posedge sys_clk) disable iff (!rstn)
      (fall && cnt_nxt == ADDR_EDGE && cmd_r[3:0] == CMD_PDOWN) |=> pd_r;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power down not entered"); // R7

  property p_pd_idle;
    @(posedge sys_clk) disable iff (!rstn) (pd_r && !sar_busy) |=> (!sar_busy && $stable(word_r));
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("conversion while powered down"); // R8

  property p_wake;
    @(posedge sys_clk) disable iff (!rstn)
      (fall && cnt_nxt == ADDR_EDGE && cmd_r[3:0] != CMD_PDOWN) |=> !pd_r;
  endproperty
  a_wake: assert property (p_wake) else $error("valid address did not wake"); // R11

  property p_bbm;
    @(posedge sys_clk) disable iff (!rstn) $changed(mux_sel_r) |-> (!mux_con_r && !$past(mux_con_r));
  endproperty
  a_bbm: assert property (p_bbm) else $error("selector switched while connected"); // R14

  property p_hold;
    @(posedge sys_clk) disable iff (!rstn) conv_start |=> (!samp_r && !mux_con_r && !eoc_r);
  endproperty
  a_hold: assert property (p_hold) else $error("sample not held at last fall"); // R15

  property p_eoc_up;
    @(posedge sys_clk) disable iff (!rstn) sar_done |=> (eoc_r && sh_r == word_r);
  endproperty
  a_eoc_up: assert property (p_eoc_up) else $error("end flag not raised on completion"); // R20
endmodule

// >>> hw/sac_pkg.sv
package sac_pkg;
  // =====================================================
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int DEB_NS = 200;
  localparam int DEB_CYC = (DEB_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_STEP_NS = 800;
  localparam int CONV_STEP_CYC = (CONV_STEP_NS * CLK_MHZ) / 1000;
  // =====================================================
  // converter and command layout
  localparam int RES_W = 12;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [3:0] CMD_PDOWN = 4'hE;
  localparam logic [3:0] CMD_LAST_EXT = 4'hA;
  localparam logic [1:0] LEN_8 = 2'h1;
  localparam logic [1:0] LEN_16 = 2'h3;
  localparam logic [1:0] LEN_RST = 2'h0;
  localparam logic [CNT_W-1:0] BITS_8 = 5'h08;
  localparam logic [CNT_W-1:0] BITS_12 = 5'h0C;
  localparam logic [CNT_W-1:0] BITS_16 = 5'h10;
  localparam logic [CNT_W-1:0] ADDR_EDGE = 5'h04;
  localparam logic [CNT_W-1:0] LEN_EDGE = 5'h06;
  localparam logic [CNT_W-1:0] CMD_EDGE = 5'h08;
  localparam logic [RES_W-1:0] RES_RST = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  // sync vector positions
  localparam int SY_CS = 0;
  localparam int SY_CLK = 1;
  localparam int SY_DIN = 2;
  localparam int SY_CMP = 3;
  localparam logic [3:0] SY_RST = 4'h1;
endpackage

// >>> hw/sac_sar.sv
`timescale 1ns/100ps
module sac_sar #(
  parameter int WIDTH = 12,
  parameter int STEP_CYC = 80
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_above,
  // status and result
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] trial_r,
  output logic [WIDTH-1:0] result_r
);
  import sac_pkg::*;

  logic [$clog2(STEP_CYC+1)-1:0] div_r;
  logic [$clog2(WIDTH)-1:0] idx_r;
  logic busy_r;
  logic done_r;
  logic tick;
  logic [WIDTH-1:0] trial_nxt;

  // =====================================================
  // conversion clock: divider held clear while idle, counts only while busy, independent of host clock
  assign tick = (div_r == STEP_CYC[$bits(div_r)-1:0] - 1'b1);
  always_ff @(posedge sys_clk) begin
    if (!rstn || !busy_r || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // decision: node above trip records 0 and drops the weight, else keep 1
  always_comb begin
    trial_nxt = trial_r;
    trial_nxt[idx_r] = ~cmp_above; // R17
    if (idx_r != '0) begin
      trial_nxt[idx_r - 1'b1] = 1'b1;
    end
  end

  // =====================================================
  // one bit per conversion clock step, msb first
  always_ff @(posedge sys_clk) begin
    if (!rstn || abort) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      idx_r <= '0;
      trial_r <= '0;
    end else if (start) begin
      busy_r <= 1'b1; // R21
      done_r <= 1'b0;
      idx_r <= ($bits(idx_r))'(WIDTH - 1); // R16
      trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (busy_r && tick) begin
      trial_r <= trial_nxt; // R21
      idx_r <= idx_r - 1'b1; // R16
      busy_r <= (idx_r != '0);
      done_r <= (idx_r == '0);
    end else begin
      done_r <= 1'b0;
    end
  end

  // result only replaced by a finished conversion; saturation falls out of the search
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      result_r <= '0;
    end else if (busy_r && tick && idx_r == '0) begin
      result_r <= trial_nxt; // R18
    end
  end

  assign busy = busy_r;
  assign done = done_r;

  property p_sar_zero;
    @(posedge sys_clk) disable iff (!rstn || abort)
      (busy_r && tick && cmp_above) |=> (trial_r[$past(idx_r)] == 1'b0);
  endproperty
  a_sar_zero: assert property (p_sar_zero) else $error("decision above trip did not record zero"); // R17

  property p_sar_len;
    @(posedge sys_clk) disable iff (!rstn || abort)
      (start && !busy_r) |=> busy_r [*8];
  endproperty
  a_sar_len: assert property (p_sar_len) else $error("conversion ended too early"); // R16
endmodule

// >>> verification/sac_host_model.sv
`timescale 1ns/100ps
// =====================================================
// host serial port model
module sac_host_model #(
  parameter int HALF = 8
) (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic cs_n,
  output logic io_clk,
  output logic data_in,
  input wire logic data_out
);
  int seed = 32'h776b;

  // idle: deselected, shift clock parked low
  initial begin
    cs_n = 1'b1;
    io_clk = 1'b0;
    data_in = 1'($random(seed));
  end

  // select changes only between cycles
  task automatic set_cs(input logic v);
    @(negedge sys_clk);
    cs_n = v;
  endtask

  // one whole cycle of n clocks, command msb first, input then random padding
  task automatic xfer(input logic [7:0] cmd, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    for (int i = 0; i < n; i++) begin
      if (i < 8) begin
        data_in = cmd[7-i];
      end else begin
        data_in = 1'($random(seed)); // padding bits must not reach the command
      end
      repeat (HALF) @(negedge sys_clk);
      io_clk = 1'b1;
      rd[15-i] = data_out;
      repeat (HALF) @(negedge sys_clk);
      io_clk = 1'b0;
    end
  endtask
endmodule

// >>> verification/test_serial_adc_control_sar_sequencer.sv
`timescale 1ns/100ps
module test_serial_adc_control_sar_sequencer;
  import sac_pkg::*;
  // short counts keep the run brief
  localparam int DEB = 4;
  localparam int STEP = 8;
  logic sys_clk, rstn, cs_n, io_clk, data_in, data_out, data_out_oe, eoc, cmp_above;
  logic [3:0] mux_sel;
  logic mux_connect, sample_close, power_down;
  logic [RES_W-1:0] trial_weights;
  logic [11:0] ch_val [16];
  logic [11:0] held;
  logic [15:0] exp_w, rd;
  logic [3:0] code, prev_sel;
  logic [1:0] len;
  logic bip, prev_con, lf;
  int exp_n, failures, compares, seed;

  // =====================================================
  // design and host
  sac_ctrl #(.DEB_CYCLES(DEB), .STEP_CYCLES(STEP)) DUT (.sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n),
    .io_clk(io_clk), .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe), .eoc(eoc),
    .cmp_above(cmp_above), .mux_sel(mux_sel), .mux_connect(mux_connect), .sample_close(sample_close),
    .trial_weights(trial_weights), .power_down(power_down));
  sac_host_model #(.HALF(8)) host (.sys_clk(sys_clk), .cs_n(cs_n), .io_clk(io_clk), .data_in(data_in),
    .data_out(data_out));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // =====================================================
  // analog front end: held sample against trial weights
  always @(negedge sys_clk) begin
    if (sample_close === 1'b1) held <= ch_val[mux_sel];
    cmp_above <= (trial_weights > held);
  end

  // selector must open before the code moves
  always @(negedge sys_clk) begin
    if (rstn === 1'b1 && mux_sel !== prev_sel && (mux_connect !== 1'b0 || prev_con !== 1'b0)) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, mux_connect, 1'b0);
    end
    prev_sel <= mux_sel;
    prev_con <= mux_connect;
  end

  // =====================================================
  // expectations
  function automatic int nbits(logic [1:0] l);
    return (l == LEN_8) ? 8 : ((l == LEN_16) ? 16 : 12);
  endfunction

  function automatic logic [15:0] msk(int n);
    return 16'hFFFF << (16 - n);
  endfunction

  // word as shifted out, sign bit flipped in bipolar form, the n sent bits reversed in lsb-first form
  function automatic logic [15:0] fmt(logic [11:0] res, logic b, int n, logic lb);
    logic [15:0] w;
    logic [15:0] r;
    w = {res ^ {b, 11'h000}, 4'h0};
    if (n == 8) w[7:0] = 8'h00;
    r = 16'h0000;
    for (int i = 0; i < n; i++) r[15-i] = w[16-n+i];
    return lb ? r : w;
  endfunction

  task automatic stop_test;
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bounded wait for the end flag to reach v
  task automatic wait_eoc(input logic v);
    int k;
    k = 0;
    while (eoc !== v && k < 12 * STEP + 64) begin
      @(negedge sys_clk);
      k++;
    end
    if (eoc !== v) begin
      check(eoc, v);
      stop_test();
    end
  endtask

  // one cycle: compare the earlier word, then follow the conversion it starts
  task automatic run_cycle(input logic [3:0] c, input logic [1:0] l, input logic b, input logic lb);
    int n, m;
    n = nbits(l);
    m = (n < exp_n) ? n : exp_n;
    host.xfer({c, l, lb, b}, n, rd);
    check(rd & msk(m), exp_w & msk(m));
    @(negedge sys_clk);
    if (c != CMD_PDOWN) begin
      check(mux_sel, c);
      check(sample_close, 16'h0001);
      check(power_down, 16'h0000);
      wait_eoc(1'b0);
      check({sample_close, mux_connect}, 16'h0000);
      wait_eoc(1'b1);
      exp_w = fmt(ch_val[c], b, n, lb);
      exp_n = n;
    end else begin
      check(power_down, 16'h0001);
      repeat (12 * STEP + 20) begin
        @(negedge sys_clk);
        if (eoc !== 1'b1) check(eoc, 16'h0001);
      end
    end
  endtask

  // =====================================================
  // main sequence
  initial begin
    seed = 32'h776b;
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    held = 12'h000;
    prev_sel = 4'h0;
    prev_con = 1'b0;
    exp_w = WORD_RST;
    exp_n = 12;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    check({power_down, eoc, data_out_oe}, 16'h0006);
    host.set_cs(1'b0);
    repeat (DEB + 8) @(negedge sys_clk);
    check(data_out_oe, 16'h0001);
    // codes 0 to 13 once, then random traffic with two power downs in a row
    for (int i = 0; i < 26; i++) begin
      for (int c = 0; c < 16; c++) ch_val[c] = 12'($random(seed));
      ch_val[0] = 12'h000;
      ch_val[10] = 12'hFFF;
      ch_val[11] = 12'h800;
      ch_val[12] = 12'h000;
      ch_val[13] = 12'hFFF;
      code = (i < 14) ? 4'(i) : 4'($unsigned($random(seed)) % 14);
      if (i == 16 || i == 17) code = CMD_PDOWN;
      len = 2'($random(seed));
      bip = 1'($random(seed));
      lf = 1'($random(seed));
      run_cycle(code, len, bip, lf);
    end
    // deselect releases the output and freezes the shift logic
    host.set_cs(1'b1);
    repeat (4) @(negedge sys_clk);
    check(data_out_oe, 16'h0000);
    repeat (DEB + 4) @(negedge sys_clk);
    host.xfer({CMD_PDOWN, LEN_8, 2'h0}, 8, rd);
    check(power_down, 16'h0000);
    host.set_cs(1'b0);
    repeat (DEB + 8) @(negedge sys_clk);
    // abort a running conversion; the earlier word must survive
    host.xfer({4'h3, LEN_RST, 2'h0}, 12, rd);
    check(rd & msk(8), exp_w & msk(8));
    wait_eoc(1'b0);
    host.set_cs(1'b1);
    repeat (DEB + 4) @(negedge sys_clk);
    host.set_cs(1'b0);
    repeat (DEB + 8) @(negedge sys_clk);
    check(eoc, 16'h0001);
    run_cycle(4'h5, LEN_RST, 1'b0, 1'b0);
    // reset in mid-run: back to power down with a cleared word, then a fresh conversion
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    check({power_down, eoc, data_out_oe}, 16'h0006);
    repeat (DEB + 8) @(negedge sys_clk);
    exp_w = WORD_RST;
    exp_n = 12;
    run_cycle(4'hB, LEN_16, 1'b1, 1'b1);
    stop_test();
  end
endmodule
